// >>> reset_cause_pkg.sv
// Constants, register map and state codes for the reset-cause block
package reset_cause_pkg;

   // =========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ            = 40_000_000;
   localparam int unsigned MAIN_OSC_FREQ_HZ  = 5_000_000;
   localparam int unsigned OSC_DIV           = CLK_HZ / MAIN_OSC_FREQ_HZ;
   localparam int unsigned LONG_WAIT_PERIODS = 131072;  // 2^17 periods
   localparam int unsigned SHORT_WAIT_PERIODS = 32768;  // 2^15 periods
   localparam int unsigned CER_WAIT_PERIODS  = 56;      // Ceramic periods
   localparam int unsigned CER_OSC_HZ        = 1_000_000;
   localparam int unsigned CER_WAIT_CYC      =
      (CER_WAIT_PERIODS * (CLK_HZ / CER_OSC_HZ));
   localparam int unsigned WAIT_CNT_W        = 21;

   // Build variants of the stabilization wait
   localparam logic [1:0] WAIT_SEL_LONG  = 2'h0;
   localparam logic [1:0] WAIT_SEL_SHORT = 2'h1;
   localparam logic [1:0] WAIT_SEL_FIXED = 2'h2;

   // =========================================================
   // Register indices (byte address is four times the index)
   localparam int unsigned ADDR_W          = 16;
   localparam logic [11:0] IDX_CTRL        = 12'hfc0;
   localparam logic [11:0] IDX_IRQ_STATUS  = 12'hfc1;
   localparam logic [11:0] IDX_IRQ_ENABLE  = 12'hfc2;
   localparam logic [11:0] IDX_IRQ_CLEAR   = 12'hfc3;
   localparam logic [11:0] IDX_TCLR_WD     = 12'hfc4;
   localparam logic [11:0] IDX_TCLR_KEY    = 12'hfc5;
   localparam logic [11:0] IDX_CAUSE       = 12'hfc6;

   // Field positions
   localparam int unsigned WD_FLAG_BIT     = 2;
   localparam int unsigned KEY_FLAG_BIT    = 3;
   localparam int unsigned CTRL_KEY_EN_BIT = 0;
   localparam int unsigned IRQ_WD_BIT      = 0;
   localparam int unsigned IRQ_KEY_BIT     = 1;
   localparam int unsigned IRQ_WAIT_BIT    = 2;
   localparam int unsigned KEY_PINS        = 4;

   // Values after reset and bus response codes
   localparam logic       FLAG_RST      = 1'b0;
   localparam logic [0:0] CTRL_RST      = 1'h0;
   localparam logic [2:0] IRQ_RST       = 3'h0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // Sequencer states
   typedef enum logic [2:0]
   {
      ST_RUN  = 3'b001,
      ST_HOLD = 3'b010,
      ST_WAIT = 3'b100
   } seq_state_t;

endpackage

// >>> stab_wait_timer.sv
// Oscillation stabilization wait counter
`timescale 1ns/1ps
`default_nettype none
module stab_wait_timer
   import reset_cause_pkg::*;
#(
   parameter logic [WAIT_CNT_W-1:0] WAIT_CYC = 21'h000100
)
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Control
   input  wire logic start_in,
   output var  logic busy_out,
   output var  logic done_out
);

   logic [WAIT_CNT_W-1:0] cnt_q;
   logic                  last;
   logic                  near;

   assign last = (cnt_q == WAIT_CYC - 21'h000001);
   // Done leads the end of busy by one cycle, so the sequencer leaves
   // the wait exactly on time; needs WAIT_CYC of at least 2
   assign near = (cnt_q == WAIT_CYC - 21'h000002);

   // =========================================================
   // Counter: busy for exactly WAIT_CYC cycles after start
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_q    <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= busy_out & near;
         if (start_in)
         begin
            cnt_q    <= '0;
            busy_out <= 1'b1;
         end
         else if (busy_out)
         begin
            cnt_q    <= cnt_q + 21'h000001;
            busy_out <= ~last;
         end
      end
   end

endmodule
`default_nettype wire

// >>> reset_cause_flags.sv
// Reset-cause flags, stabilization wait sequencer and AXI4-Lite registers
// Summary of operation
// [R1] - Watchdog cause flag is bit 2, key cause flag bit 3 of index fc6.
// [R2] - The external reset pin forces both cause flags to 0.
// [R3] - A watchdog overflow reset sets the watchdog flag, key flag held.
// [R4] - A key-return input reset sets the key cause flag to 1.
// [R5] - A key-return reset leaves the watchdog flag as it was.
// [R6] - A set flag stays set until external reset or its clear action.
// [R7] - Software tests and clears both flags after each reset start.
// [R8] - Clearing the watchdog flag zeroes it and keeps the key flag.
// [R9] - Leaving standby by reset waits 2^17 or 2^15 main osc periods.
// [R10] - The fixed variant waits 56 ceramic oscillator periods instead.
// [R11] - Test-and-clear reads a flag and clears it in one access.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags
   import reset_cause_pkg::*;
#(
   parameter logic [1:0]            WAIT_SEL      = WAIT_SEL_LONG,
   parameter logic [WAIT_CNT_W-1:0] LONG_WAIT_CYC =
      WAIT_CNT_W'(LONG_WAIT_PERIODS * OSC_DIV),
   parameter logic [WAIT_CNT_W-1:0] SHORT_WAIT_CYC =
      WAIT_CNT_W'(SHORT_WAIT_PERIODS * OSC_DIV)
)
(
   // Clock and external reset pin
   input  wire logic              CORE_CLK_IN,
   input  wire logic              RST_B_IN,
   // Reset sources and core status
   input  wire logic              WDT_OVF_IN,
   input  wire logic [3:0]        KEY_RETURN_IN,
   input  wire logic              STANDBY_IN,
   // Core reset, wait status and interrupt
   output var  logic              SYS_RESET_OUT,
   output var  logic              OSC_WAIT_OUT,
   output var  logic              IRQ_OUT,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
   input  wire logic              AXI_AWVALID_IN,
   output var  logic              AXI_AWREADY_OUT,
   // AXI4-Lite write data
   input  wire logic [31:0]       AXI_WDATA_IN,
   input  wire logic [3:0]        AXI_WSTRB_IN,
   input  wire logic              AXI_WVALID_IN,
   output var  logic              AXI_WREADY_OUT,
   // AXI4-Lite write response
   output var  logic [1:0]        AXI_BRESP_OUT,
   output var  logic              AXI_BVALID_OUT,
   input  wire logic              AXI_BREADY_IN,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
   input  wire logic              AXI_ARVALID_IN,
   output var  logic              AXI_ARREADY_OUT,
   // AXI4-Lite read data
   output var  logic [31:0]       AXI_RDATA_OUT,
   output var  logic [1:0]        AXI_RRESP_OUT,
   output var  logic              AXI_RVALID_OUT,
   input  wire logic              AXI_RREADY_IN
);

   // =========================================================
   // Decode helper
   // True when a byte address hits the word of register index idx
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [11:0]       idx);
      hit = (addr[ADDR_W-1:2] == {2'b00, idx});
   endfunction

   // True inside the contiguous register window fc0 to fc6
   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = (addr[ADDR_W-1:2] >= {2'b00, IDX_CTRL}) &&
               (addr[ADDR_W-1:2] <= {2'b00, IDX_CAUSE});
   endfunction

   // Wait length for this build, chosen once at elaboration
   localparam logic [WAIT_CNT_W-1:0] WAIT_CYC =
      (WAIT_SEL == WAIT_SEL_SHORT) ? SHORT_WAIT_CYC :
      (WAIT_SEL == WAIT_SEL_FIXED) ? WAIT_CNT_W'(CER_WAIT_CYC) :
      LONG_WAIT_CYC;

   // =========================================================
   // Declarations
   logic [1:0]              rst_sync_q;
   logic                    rst_n;
   logic [KEY_PINS-1:0]     key_s1_q, key_s2_q, key_old_q, key_fall;
   logic                    key_evt, wd_evt;
   logic                    wd_flag_q, wd_flag_d, key_flag_q, key_flag_d;
   logic                    key_en_q, key_en_d;
   logic [2:0]              irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
   logic [2:0]              irq_evt, irq_clr;
   seq_state_t              state_q, state_d;
   logic                    boot_q, standby_q;
   logic                    wait_start, wait_busy, wait_done;
   logic                    aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [ADDR_W-1:0]       awaddr_q;
   logic [7:0]              wdata_q;
   logic                    wstrb0_q;
   logic                    do_wr, wr_ok, wr_low;
   logic                    wr_cause, wr_ctrl, wr_en, wr_clr;
   logic                    ar_hs, rd_ok, rd_tclr_wd, rd_tclr_key;
   logic [31:0]             rd_data;
   logic                    wd_clr, key_clr;

   // =========================================================
   // Reset release: asserted at once, released through two flops
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // =========================================================
   // Key-return pins: two-flop synchronisers and falling-edge detect
   genvar gi;
   generate
      for (gi = 0; gi < KEY_PINS; gi = gi + 1)
      begin : g_key
         always_ff @(posedge CORE_CLK_IN or negedge rst_n)
         begin
            if (!rst_n)
            begin
               key_s1_q[gi]  <= 1'b1;
               key_s2_q[gi]  <= 1'b1;
               key_old_q[gi] <= 1'b1;
            end
            else
            begin
               key_s1_q[gi]  <= KEY_RETURN_IN[gi];
               key_s2_q[gi]  <= key_s1_q[gi];
               key_old_q[gi] <= key_s2_q[gi];
            end
         end
         // Only the second stage feeds the edge detector
         assign key_fall[gi] = key_old_q[gi] & ~key_s2_q[gi];
      end
   endgenerate

   // Reset events; key wake-up is gated by software enable
   assign key_evt = key_en_q & (|key_fall);
   assign wd_evt  = WDT_OVF_IN;

   // =========================================================
   // AXI write path decode
   assign do_wr    = aw_full_q & w_full_q & ~AXI_BVALID_OUT;
   assign wr_low   = do_wr & wstrb0_q;
   assign wr_cause = wr_low & hit(awaddr_q, IDX_CAUSE);
   assign wr_ctrl  = wr_low & hit(awaddr_q, IDX_CTRL);
   assign wr_en    = wr_low & hit(awaddr_q, IDX_IRQ_ENABLE);
   assign wr_clr   = wr_low & hit(awaddr_q, IDX_IRQ_CLEAR);
   assign wr_ok    = mapped(awaddr_q);

   // =========================================================
   // AXI read path decode; a test-and-clear acts at address accept
   assign ar_hs       = AXI_ARVALID_IN & AXI_ARREADY_OUT;
   assign rd_tclr_wd  = ar_hs & hit(AXI_ARADDR_IN, IDX_TCLR_WD);
   assign rd_tclr_key = ar_hs & hit(AXI_ARADDR_IN, IDX_TCLR_KEY);
   assign rd_ok       = mapped(AXI_ARADDR_IN);

   // Read mux; write-only clear register reads as zero
   assign rd_data =
      (hit(AXI_ARADDR_IN, IDX_CAUSE) | hit(AXI_ARADDR_IN, IDX_TCLR_WD) |
       hit(AXI_ARADDR_IN, IDX_TCLR_KEY)) ?
         {28'h0000000, key_flag_q, wd_flag_q, 2'h0} :            // [R1]
      hit(AXI_ARADDR_IN, IDX_CTRL) ?
         {28'h0000000, OSC_WAIT_OUT, SYS_RESET_OUT, 1'b0, key_en_q} :
      hit(AXI_ARADDR_IN, IDX_IRQ_STATUS) ? {29'h00000000, irq_stat_q} :
      hit(AXI_ARADDR_IN, IDX_IRQ_ENABLE) ? {29'h00000000, irq_en_q} :
      32'h00000000;

   // =========================================================
   // Flag clears: write of 0 to a flag bit, or test-and-clear read
   assign wd_clr  = (wr_cause & ~wdata_q[WD_FLAG_BIT]) | rd_tclr_wd;   // [R8]
   assign key_clr = (wr_cause & ~wdata_q[KEY_FLAG_BIT]) | rd_tclr_key;

   // Set beats clear, so a cause landing with a clear is never lost
   assign wd_flag_d  = wd_evt | (wd_flag_q & ~wd_clr);     // [R3] [R6] [R11]
   assign key_flag_d = key_evt | (key_flag_q & ~key_clr);  // [R4] [R6] [R11]

   // Of the resets only the external pin clears the flags, never internal resets
   always_ff @(posedge CORE_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_flag_q  <= FLAG_RST;                            // [R2]
         key_flag_q <= FLAG_RST;                            // [R2]
      end
      else
      begin
         wd_flag_q  <= wd_flag_d;                           // [R5]
         key_flag_q <= key_flag_d;                          // [R8]
      end
   end

   // =========================================================
   // Control and interrupt registers
   assign key_en_d   = wr_ctrl ? wdata_q[CTRL_KEY_EN_BIT] : key_en_q;
   assign irq_en_d   = wr_en ? wdata_q[2:0] : irq_en_q;
   assign irq_clr    = wr_clr ? wdata_q[2:0] : 3'h0;
   assign irq_evt    = {wait_done, key_evt, wd_evt};
   assign irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);

   // Interrupt level changes in the same cycle as status, kept registered
   always_ff @(posedge CORE_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_en_q   <= CTRL_RST;
         irq_en_q   <= IRQ_RST;
         irq_stat_q <= IRQ_RST;
         IRQ_OUT    <= 1'b0;
      end
      else
      begin
         key_en_q   <= key_en_d;
         irq_en_q   <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         IRQ_OUT    <= |(irq_stat_d & irq_en_d);
      end
   end

   // =========================================================
   // Reset sequencer: hold one cycle, then wait after boot or if leaving standby
   assign wait_start = (state_q == ST_HOLD) & (standby_q | boot_q);   // [R9]

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN:
            if (wd_evt | key_evt)
               state_d = ST_HOLD;
         ST_HOLD:
            state_d = wait_start ? ST_WAIT : ST_RUN;
         ST_WAIT:
            if (wait_done | ~wait_busy)  // Busy low guards tiny builds
               state_d = ST_RUN;
         default:
            state_d = ST_HOLD;
      endcase
   end

   // Standby is sampled with the event so the wait decision is stable
   always_ff @(posedge CORE_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q       <= ST_HOLD;
         boot_q        <= 1'b1;
         standby_q     <= 1'b0;
         SYS_RESET_OUT <= 1'b1;
         OSC_WAIT_OUT  <= 1'b0;
      end
      else
      begin
         state_q       <= state_d;
         boot_q        <= 1'b0;
         if (state_q == ST_RUN)
            standby_q  <= STANDBY_IN;
         SYS_RESET_OUT <= (state_d != ST_RUN);
         OSC_WAIT_OUT  <= (state_d == ST_WAIT);
      end
   end

   // Wait length fixed per build: long, short or ceramic variant
   stab_wait_timer
   #(
      .WAIT_CYC (WAIT_CYC)                                  // [R9] [R10]
   )
   u_wait
   (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (rst_n),
      .start_in (wait_start),
      .busy_out (wait_busy),
      .done_out (wait_done)
   );

   // =========================================================
   // AXI write channel: address and data taken in either order
   assign aw_full_d = (aw_full_q | (AXI_AWVALID_IN & AXI_AWREADY_OUT)) &
                      ~do_wr;
   assign w_full_d  = (w_full_q | (AXI_WVALID_IN & AXI_WREADY_OUT)) &
                      ~do_wr;

   always_ff @(posedge CORE_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_full_q       <= 1'b0;
         w_full_q        <= 1'b0;
         awaddr_q        <= '0;
         wdata_q         <= 8'h00;
         wstrb0_q        <= 1'b0;
         AXI_AWREADY_OUT <= 1'b0;
         AXI_WREADY_OUT  <= 1'b0;
         AXI_BVALID_OUT  <= 1'b0;
         AXI_BRESP_OUT   <= RESP_OKAY;
      end
      else
      begin
         aw_full_q       <= aw_full_d;
         w_full_q        <= w_full_d;
         AXI_AWREADY_OUT <= ~aw_full_d;
         AXI_WREADY_OUT  <= ~w_full_d;
         if (AXI_AWVALID_IN & AXI_AWREADY_OUT)
            awaddr_q <= AXI_AWADDR_IN;
         if (AXI_WVALID_IN & AXI_WREADY_OUT)
         begin
            wdata_q  <= AXI_WDATA_IN[7:0];
            wstrb0_q <= AXI_WSTRB_IN[0];
         end
         if (do_wr)
         begin
            AXI_BVALID_OUT <= 1'b1;
            AXI_BRESP_OUT  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (AXI_BREADY_IN)
            AXI_BVALID_OUT <= 1'b0;
      end
   end

   // =========================================================
   // AXI read channel: one read in flight, data one cycle after accept
   always_ff @(posedge CORE_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         AXI_ARREADY_OUT <= 1'b0;
         AXI_RVALID_OUT  <= 1'b0;
         AXI_RDATA_OUT   <= 32'h00000000;
         AXI_RRESP_OUT   <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         AXI_ARREADY_OUT <= 1'b0;
         AXI_RVALID_OUT  <= 1'b1;
         AXI_RDATA_OUT   <= rd_data;                        // [R11]
         AXI_RRESP_OUT   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (AXI_RVALID_OUT)
      begin
         if (AXI_RREADY_IN)
         begin
            AXI_RVALID_OUT  <= 1'b0;
            AXI_ARREADY_OUT <= 1'b1;
         end
      end
      else
         AXI_ARREADY_OUT <= 1'b1;
   end

endmodule
`default_nettype wire

// >>> reset_cause_flags_checker.sv
// Port-level assertions for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags_checker
   import reset_cause_pkg::*;
#(
   parameter logic [1:0]            WAIT_SEL       = WAIT_SEL_LONG,
   parameter logic [WAIT_CNT_W-1:0] LONG_WAIT_CYC  = 21'h000100,
   parameter logic [WAIT_CNT_W-1:0] SHORT_WAIT_CYC = 21'h000100
)
(
   // Clock, reset and core side
   input  wire logic              CORE_CLK_IN,
   input  wire logic              RST_B_IN,
   input  wire logic              WDT_OVF_IN,
   input  wire logic              STANDBY_IN,
   input  wire logic              SYS_RESET_OUT,
   input  wire logic              OSC_WAIT_OUT,
   input  wire logic              IRQ_OUT,
   // Read channels
   input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
   input  wire logic              AXI_ARVALID_IN,
   input  wire logic              AXI_ARREADY_OUT,
   input  wire logic [31:0]       AXI_RDATA_OUT,
   input  wire logic [1:0]        AXI_RRESP_OUT,
   input  wire logic              AXI_RVALID_OUT
);
   // =========================================================
   // Helper logic
   localparam logic [WAIT_CNT_W-1:0] WAIT_EXP =
      (WAIT_SEL == WAIT_SEL_SHORT) ? SHORT_WAIT_CYC :
      (WAIT_SEL == WAIT_SEL_FIXED) ? WAIT_CNT_W'(CER_WAIT_CYC) :
      LONG_WAIT_CYC;
   logic [WAIT_CNT_W-1:0] wcnt_q;
   logic [WAIT_CNT_W-1:0] wcnt_d;
   logic [ADDR_W-1:0]     ar_q;
   logic [ADDR_W-1:0]     ar_d;
   logic                  in_map;
   logic                  is_cause;

   // Count wait cycles and remember the last accepted read address
   assign wcnt_d = OSC_WAIT_OUT ? wcnt_q + 1'b1 : '0;
   assign ar_d = (AXI_ARVALID_IN && AXI_ARREADY_OUT) ? AXI_ARADDR_IN : ar_q;
   assign in_map = (ar_q[15:2] >= {2'h0, IDX_CTRL}) &&
                   (ar_q[15:2] <= {2'h0, IDX_CAUSE});
   assign is_cause = (ar_q[15:2] == {2'h0, IDX_CAUSE}) ||
                     (ar_q[15:2] == {2'h0, IDX_TCLR_WD}) ||
                     (ar_q[15:2] == {2'h0, IDX_TCLR_KEY});

   // Registers cleared by the pin so a second reset starts clean
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         wcnt_q <= '0;
         ar_q   <= '0;
      end
      else
      begin
         wcnt_q <= wcnt_d;
         ar_q   <= ar_d;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   wd_reset_a: assert property (
      !SYS_RESET_OUT && WDT_OVF_IN |=> SYS_RESET_OUT)
      else $error("watchdog event gave no core reset");
   hold_run_a: assert property (
      !SYS_RESET_OUT && WDT_OVF_IN && !STANDBY_IN |=>
      !OSC_WAIT_OUT ##[1:2] !SYS_RESET_OUT)
      else $error("reset outside standby did not return to run");
   standby_wait_a: assert property (
      !SYS_RESET_OUT && WDT_OVF_IN && STANDBY_IN && $past(STANDBY_IN)
      |-> ##[1:3] OSC_WAIT_OUT)
      else $error("reset from standby skipped the wait");
   wait_len_a: assert property (
      $fell(OSC_WAIT_OUT) |-> wcnt_q == WAIT_EXP)
      else $error("stabilization wait has the wrong length");
   wait_core_a: assert property (
      OSC_WAIT_OUT |-> SYS_RESET_OUT)
      else $error("core left reset during the wait");
   cause_bits_a: assert property (
      AXI_RVALID_OUT && is_cause |->
      AXI_RDATA_OUT[31:4] == 28'h0 && AXI_RDATA_OUT[1:0] == 2'h0)
      else $error("cause read shows bits outside 3:2");
   read_decode_a: assert property (
      AXI_RVALID_OUT && ar_q[1:0] == 2'h0 |->
      AXI_RRESP_OUT == (in_map ? RESP_OKAY : RESP_SLVERR))
      else $error("read response does not match the address map");
   irq_quiet_a: assert property (
      $rose(RST_B_IN) |-> !IRQ_OUT ##1 !IRQ_OUT)
      else $error("interrupt pending right after external reset");

   // Main scenarios reached
   cover property (!SYS_RESET_OUT && WDT_OVF_IN);
   cover property ($fell(OSC_WAIT_OUT));
   cover property (AXI_RVALID_OUT && AXI_RRESP_OUT == RESP_SLVERR);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import reset_cause_pkg::*;
;
   // =========================================================
   // Signals
   localparam int unsigned WAIT_N = 20; // Short wait keeps runs brief
   logic        clk = 1'b0;
   logic        rst_b, wdt, stby, sys_rst, osc_w, irq;
   logic [3:0]  key, wstrb;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   int          miscompares, cmp_count, cyc;

   always #12.5 clk = ~clk;

   reset_cause_flags #(.WAIT_SEL(WAIT_SEL_LONG), .LONG_WAIT_CYC(21'h000014),
      .SHORT_WAIT_CYC(21'h000014)) dut (
      .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .WDT_OVF_IN(wdt),
      .KEY_RETURN_IN(key), .STANDBY_IN(stby), .SYS_RESET_OUT(sys_rst),
      .OSC_WAIT_OUT(osc_w), .IRQ_OUT(irq),
      .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
      .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
      .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
      .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
      .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
      .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
      .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
      .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

   // =========================================================
   // Helpers
   function automatic logic [15:0] ba(input logic [11:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t ns: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Ready is read at the falling edge, where it equals its rising-edge value
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ah, wh, bh;
      int n;
      n = 0;
      bh = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bh && n < 100)
      begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = (bvalid === 1'b1);
         r = bresp;
         n++;
         @(posedge clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
      end
      check(32'(bh), 32'h1);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic ah, rh;
      int n;
      n = 0;
      rh = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rh && n < 100)
      begin
         @(negedge clk);
         ah = arvalid && arready;
         rh = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         n++;
         @(posedge clk);
         if (ah) arvalid <= 1'b0;
         if (rh) rready <= 1'b0;
      end
      check(32'(rh), 32'h1);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, exp);
   endtask

   // Waits for core reset (sel 0) or the wait flag (sel 1) to reach lvl
   task automatic wait_lvl(input logic sel, input logic lvl);
      int n;
      n = 0;
      while (((sel ? osc_w : sys_rst) !== lvl) && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(n < 200), 32'h1);
   endtask

   task automatic pulse_wdt();
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      wait_lvl(1'b0, 1'b1);
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      wait_lvl(1'b1, 1'b1);
      wait_lvl(1'b1, 1'b0);
      wait_lvl(1'b0, 1'b0);
   endtask

   // Hang guard; the tests need well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         $display("wrong value at %0t ns: run timed out", $time);
         give_verdict();
      end
   end

   // =========================================================
   // Tests
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      {rst_b, wdt, stby, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      key = 4'hf;
      wstrb = 4'hf;
      do_reset();
      rd_chk(ba(IDX_CAUSE), 32'h0);
      rd_chk(ba(IDX_CTRL), 32'h0);
      rd(16'h3f40, d, r);
      check(32'(r), 32'(RESP_SLVERR));
      wr(16'h3f40, 32'h1, r);
      check(32'(r), 32'(RESP_SLVERR));
      wr(ba(IDX_IRQ_CLEAR), 32'h7, r);
      rd_chk(ba(IDX_IRQ_STATUS), 32'h0);
      $display("test boot done");
      wr(ba(IDX_IRQ_ENABLE), 32'h1, r);
      pulse_wdt();
      wait_lvl(1'b0, 1'b0);
      rd_chk(ba(IDX_CAUSE), 32'h4);
      rd_chk(ba(IDX_IRQ_STATUS), 32'h1);
      @(negedge clk);
      check(32'(irq), 32'h1);
      wr(ba(IDX_IRQ_ENABLE), 32'h0, r);
      @(negedge clk);
      check(32'(irq), 32'h0);
      wr(ba(IDX_IRQ_ENABLE), 32'h1, r);
      wr(ba(IDX_IRQ_CLEAR), 32'h1, r);
      @(negedge clk);
      check(32'(irq), 32'h0);
      $display("test watchdog done");
      wr(ba(IDX_CTRL), 32'h1, r);
      @(posedge clk);
      key <= 4'hd;
      wait_lvl(1'b0, 1'b1);
      wait_lvl(1'b0, 1'b0);
      rd_chk(ba(IDX_CAUSE), 32'hc);
      rd_chk(ba(IDX_IRQ_STATUS), 32'h2);
      wr(ba(IDX_CTRL), 32'h0, r);
      key <= 4'hf;
      repeat (4) @(posedge clk);
      key <= 4'h7;
      repeat (8) @(negedge clk);
      check(32'(sys_rst), 32'h0);
      wr(ba(IDX_CAUSE), 32'hc, r);
      rd_chk(ba(IDX_CAUSE), 32'hc);
      $display("test key done");
      rd_chk(ba(IDX_TCLR_WD), 32'hc);
      rd_chk(ba(IDX_CAUSE), 32'h8);
      rd_chk(ba(IDX_TCLR_KEY), 32'h8);
      rd_chk(ba(IDX_CAUSE), 32'h0);
      pulse_wdt();
      wait_lvl(1'b0, 1'b0);
      wr(ba(IDX_CAUSE), 32'h0, r);
      check(32'(r), 32'(RESP_OKAY));
      rd_chk(ba(IDX_CAUSE), 32'h0);
      $display("test clear done");
      wr(ba(IDX_IRQ_CLEAR), 32'h7, r);
      @(posedge clk);
      stby <= 1'b1;
      pulse_wdt();
      wait_lvl(1'b1, 1'b1);
      n = 0;
      while (osc_w === 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(n), 32'(WAIT_N));
      @(posedge clk) stby <= 1'b0;
      wait_lvl(1'b0, 1'b0);
      rd_chk(ba(IDX_IRQ_STATUS), 32'h5);
      rd_chk(ba(IDX_CAUSE), 32'h4);
      $display("test standby done");
      do_reset();
      rd_chk(ba(IDX_CAUSE), 32'h0);
      $display("test second reset done");
      give_verdict();
   end
endmodule

bind reset_cause_flags reset_cause_flags_checker #(.WAIT_SEL(WAIT_SEL),
   .LONG_WAIT_CYC(LONG_WAIT_CYC), .SHORT_WAIT_CYC(SHORT_WAIT_CYC)) chk (
   .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .WDT_OVF_IN(WDT_OVF_IN),
   .STANDBY_IN(STANDBY_IN), .SYS_RESET_OUT(SYS_RESET_OUT),
   .OSC_WAIT_OUT(OSC_WAIT_OUT), .IRQ_OUT(IRQ_OUT),
   .AXI_ARADDR_IN(AXI_ARADDR_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
   .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
   .AXI_RRESP_OUT(AXI_RRESP_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT));
`default_nettype wire
